/* File: core/asu_uart.sv */
// Asynchronous serial transceiver with FIFOs and flow control
`timescale 1ns/1ps
// How it works
// - Three samples per bit, majority decides
// - Fifteen-bit reload baud generator, external clock
// - Length 5..9 normal, 7/8 multiprocessor
// - NRZ or inverted NRZ both lines
// - Start on falling, or rising when inverted
// - Framing, overrun always; parity normal only
// - Holding registers allow simultaneous transmit/receive
// - FIFOs of nine-bit entries, depth parameter
// - Each FIFO assignable to either direction
// - Each FIFO has separate reset
// - Transmit FIFO data can be resent
// - Receive FIFO interrupt level programmable
// - CTS pauses transmit, RTS throttles peer
// - Receive request on data or error
// - Transmit-empty request when shifting starts, or while the transmit FIFO is not full
// - Transmit-idle request while line idle
// - Transmit FIFO request when FIFO empty
// - Receive-data and transmit-empty requests also serve as DMA triggers
// - Multiprocessor role input has no effect; frames always sent with data flag
// - Active only in mode 0 or 1
// - Three-bit mode field, encodings zero, one
module asu_uart
	import asu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic mode_select_bit2,
	input wire logic mode_select_bit1,
	input wire logic mode_select_bit0,
	input wire logic programmable_clear,
	input wire logic [3:0] char_len,
	input wire logic parity_en,
	input wire logic parity_odd,
	input wire logic invert_nrz,
	input wire logic [ASU_RELOAD_W-1:0] baud_reload,
	input wire logic ext_clk_sel,
	input wire logic ext_clk,
	input wire logic slave_role,
	input wire logic flow_en,
	input wire logic cts_n,
	output logic rts_n,
	input wire logic fifo1_en,
	input wire logic fifo1_is_rx,
	input wire logic fifo2_en,
	input wire logic fifo2_is_rx,
	input wire logic fifo1_reset,
	input wire logic fifo2_reset,
	input wire logic tx_resend,
	input wire logic [ASU_FIFO_AW:0] rx_fifo_level,
	input wire logic tx_wr,
	input wire logic [ASU_CHAR_W-1:0] tx_data,
	input wire logic rx_rd,
	input wire logic err_clear,
	output logic [ASU_CHAR_W-1:0] rx_data,
	output logic rx_full,
	output logic rx_addr_flag,
	output logic parity_err,
	output logic frame_err,
	output logic overrun_err,
	output logic tx_empty,
	output logic tx_idle,
	output logic txd,
	input wire logic rxd,
	output logic rx_irq,
	output logic tx_irq,
	output logic tx_idle_irq,
	output logic tx_fifo_irq,
	output logic rx_dma_req,
	output logic tx_dma_req
);
	logic [2:0] mode;
	logic active, mp, tick, ext_q, ext_edge, line_in, rx_prev_q;
	logic [3:0] len, rx_bit_q, tx_bit_q;
	logic [ASU_RELOAD_W-1:0] baud_cnt_q;
	asu_state_type rx_st_q, tx_st_q;
	logic [1:0] votes_q, nsamp_q, tx_ph_q;
	logic [ASU_CHAR_W-1:0] rx_sh_q, rx_word, tx_holding_reg_q;
	logic [ASU_CHAR_W-1:0] rx_holding_reg_q, f1_q, f2_q, txf_q, rxf_q;
	logic [ASU_CHAR_W:0] tx_sh_q;
	logic rx_par_q, rx_done, rx_fe, rx_pe, tx_hold_full_q, tx_par_q;
	logic tx_line_q, tx_load, rx_full_q, tx_fifo_on, rx_fifo_on, tx_src_ok;
	logic f1_wr, f1_rd, f2_wr, f2_rd, f1_empty, f2_empty, f1_full, f2_full;
	logic [ASU_FIFO_AW:0] f1_lvl, f2_lvl, rxf_lvl;
	logic txf_empty, txf_full, rxf_empty, rxf_full;

	// Majority of three samples
	function automatic logic maj(input logic [1:0] ones);
		maj = (ones >= 2'h2);
	endfunction

	// Even parity over the active character bits
	function automatic logic par(input logic [ASU_CHAR_W-1:0] d,
	                             input logic [3:0] n);
		logic p;
		p = 1'b0;
		for (int i = 0; i < ASU_CHAR_W; i++) begin
			if (4'(i) < n) begin
				p = p ^ d[i];
			end
		end
		par = p;
	endfunction

	// Mode decode and length limiting
	assign mode = {mode_select_bit2, mode_select_bit1, mode_select_bit0};
	assign active = (mode == ASU_MODE_NORMAL) ||
	                (mode == ASU_MODE_MULTIPROC);
	assign mp = (mode == ASU_MODE_MULTIPROC);
	always_comb begin
		len = char_len;
		if (mp) begin
			len = (char_len == ASU_LEN_MP7) ? ASU_LEN_MP7 : ASU_LEN_MP8;
		end else if (char_len < ASU_LEN_MIN) begin
			len = ASU_LEN_MIN;
		end else if (char_len > ASU_LEN_MAX) begin
			len = ASU_LEN_MAX;
		end
	end

	// Line polarity
	assign line_in = rxd ^ invert_nrz;
	assign txd = tx_line_q ^ invert_nrz;

	// External clock edge for the reload counter
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ext_q <= 1'b0;
		end else begin
			ext_q <= ext_clk;
		end
	end
	assign ext_edge = ext_clk && !ext_q;

	// Baud generator: down-count, reload at zero, tick per reload
	always_ff @(posedge mclk) begin
		if (!rst_n || programmable_clear || !active) begin
			baud_cnt_q <= ASU_RELOAD_RST;
		end else if (!ext_clk_sel || ext_edge) begin
			if (baud_cnt_q == '0) begin
				baud_cnt_q <= baud_reload;
			end else begin
				baud_cnt_q <= baud_cnt_q - 1'b1;
			end
		end
	end
	assign tick = (baud_cnt_q == '0) && (!ext_clk_sel || ext_edge);

	// FIFO routing by software selection
	assign tx_fifo_on = (fifo1_en && !fifo1_is_rx) ||
	                    (fifo2_en && !fifo2_is_rx);
	assign rx_fifo_on = (fifo1_en && fifo1_is_rx) ||
	                    (fifo2_en && fifo2_is_rx);
	assign txf_q = (fifo1_en && !fifo1_is_rx) ? f1_q : f2_q;
	assign txf_empty = (fifo1_en && !fifo1_is_rx) ? f1_empty : f2_empty;
	assign txf_full = (fifo1_en && !fifo1_is_rx) ? f1_full : f2_full;
	assign rxf_q = (fifo1_en && fifo1_is_rx) ? f1_q : f2_q;
	assign rxf_empty = (fifo1_en && fifo1_is_rx) ? f1_empty : f2_empty;
	assign rxf_full = (fifo1_en && fifo1_is_rx) ? f1_full : f2_full;
	assign rxf_lvl = (fifo1_en && fifo1_is_rx) ? f1_lvl : f2_lvl;
	assign f1_wr = fifo1_en && (fifo1_is_rx ? rx_done && !rx_fe && !rx_pe
	               : tx_wr);
	assign f2_wr = fifo2_en && !(fifo1_en && fifo1_is_rx == fifo2_is_rx) &&
	               (fifo2_is_rx ? rx_done && !rx_fe && !rx_pe : tx_wr);
	assign f1_rd = fifo1_en && (fifo1_is_rx ? rx_rd : tx_load);
	assign f2_rd = fifo2_en && !(fifo1_en && fifo1_is_rx == fifo2_is_rx) &&
	               (fifo2_is_rx ? rx_rd : tx_load);

	// Two FIFOs, each with its own clear
	asu_fifo u_fifo1 (
		.mclk(mclk), .rst_n(rst_n),
		.clear(fifo1_reset || programmable_clear),
		.rewind(tx_resend && !fifo1_is_rx),
		.wr_en(f1_wr), .wr_data(fifo1_is_rx ? rx_word : tx_data),
		.rd_en(f1_rd), .rd_data(f1_q), .empty(f1_empty), .full(f1_full),
		.level(f1_lvl)
	);
	asu_fifo u_fifo2 (
		.mclk(mclk), .rst_n(rst_n),
		.clear(fifo2_reset || programmable_clear),
		.rewind(tx_resend && !fifo2_is_rx),
		.wr_en(f2_wr), .wr_data(fifo2_is_rx ? rx_word : tx_data),
		.rd_en(f2_rd), .rd_data(f2_q), .empty(f2_empty), .full(f2_full),
		.level(f2_lvl)
	);

	// Transmit holding register when no FIFO feeds the shifter
	always_ff @(posedge mclk) begin
		if (!rst_n || programmable_clear) begin
			tx_hold_full_q <= 1'b0;
			tx_holding_reg_q <= '0;
		end else if (!tx_fifo_on && tx_wr) begin
			tx_hold_full_q <= 1'b1;
			tx_holding_reg_q <= tx_data;
		end else if (tx_load) begin
			tx_hold_full_q <= 1'b0;
		end
	end
	assign tx_src_ok = tx_fifo_on ? !txf_empty : tx_hold_full_q;
	assign tx_load = active && tx_st_q == ASU_IDLE && tx_src_ok && tick &&
	                 !(flow_en && cts_n);

	// Transmit shifter: start, data, parity or flag, stop; three ticks a bit
	always_ff @(posedge mclk) begin
		if (!rst_n || programmable_clear) begin
			tx_st_q <= ASU_IDLE;
			tx_line_q <= 1'b1;
			tx_sh_q <= '0;
			tx_bit_q <= '0;
			tx_par_q <= 1'b0;
			tx_ph_q <= '0;
		end else if (tick && tx_st_q != ASU_IDLE &&
		             tx_ph_q != ASU_OVERSAMPLE - 2'h1) begin
			tx_ph_q <= tx_ph_q + 2'h1;
		end else if (tick) begin
			tx_ph_q <= '0;
			case (tx_st_q)
			ASU_IDLE: begin
				tx_line_q <= 1'b1;
				if (tx_load) begin
					tx_sh_q <= {1'b0, tx_fifo_on ? txf_q : tx_holding_reg_q};
					tx_par_q <= par(tx_fifo_on ? txf_q : tx_holding_reg_q,
					                len) ^ parity_odd;
					tx_line_q <= 1'b0;
					tx_st_q <= ASU_DATA;
					tx_bit_q <= '0;
				end
			end
			ASU_DATA: begin
				if (tx_bit_q < len) begin
					tx_line_q <= tx_sh_q[0];
					tx_sh_q <= tx_sh_q >> 1;
				end else if (tx_bit_q == len && mp) begin
					tx_line_q <= 1'b0; // address/data flag, data
				end else if (tx_bit_q == len && parity_en) begin
					tx_line_q <= tx_par_q;
				end else begin
					tx_line_q <= 1'b1;
					tx_st_q <= ASU_STOP;
				end
				tx_bit_q <= tx_bit_q + 1'b1;
			end
			ASU_STOP: tx_st_q <= ASU_IDLE;
			default: tx_st_q <= ASU_IDLE;
			endcase
		end
	end

	// Receiver: edge start, three samples per bit
	always_ff @(posedge mclk) begin
		if (!rst_n || programmable_clear) begin
			rx_st_q <= ASU_IDLE;
			rx_prev_q <= 1'b1;
			votes_q <= '0;
			nsamp_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q <= '0;
			rx_par_q <= 1'b0;
		end else begin
			rx_prev_q <= line_in;
			case (rx_st_q)
			ASU_IDLE: if (active && rx_prev_q && !line_in) begin
				rx_st_q <= ASU_START;
				rx_sh_q <= '0;
				votes_q <= '0;
				nsamp_q <= '0;
				rx_bit_q <= '0;
			end
			ASU_START, ASU_DATA, ASU_STOP: begin
				if (tick) begin
					nsamp_q <= nsamp_q + 1'b1;
					votes_q <= votes_q + {1'b0, line_in};
					if (nsamp_q == ASU_OVERSAMPLE - 2'h1) begin
						nsamp_q <= '0;
						votes_q <= '0;
						rx_bit_q <= rx_bit_q + 1'b1;
						if (rx_st_q == ASU_START) begin
							rx_st_q <= ASU_DATA;
							rx_bit_q <= '0;
						end else if (rx_bit_q < len) begin
							rx_sh_q[rx_bit_q] <= maj(votes_q +
							                   {1'b0, line_in});
						end else if (rx_bit_q == len && (mp || parity_en)) begin
							rx_par_q <= maj(votes_q + {1'b0, line_in});
						end else begin
							rx_st_q <= ASU_STOP;
						end
						if (rx_st_q == ASU_STOP) begin
							rx_st_q <= ASU_IDLE;
						end
					end
				end
			end
			default: rx_st_q <= ASU_IDLE;
			endcase
		end
	end
	// Stop-bit sample ends the frame
	assign rx_done = tick && rx_st_q == ASU_DATA &&
	                 nsamp_q == ASU_OVERSAMPLE - 2'h1 &&
	                 rx_bit_q == len + ((mp || parity_en) ? 4'h1 : 4'h0);
	assign rx_fe = !maj(votes_q + {1'b0, line_in});
	assign rx_pe = !mp && parity_en &&
	               (par(rx_sh_q, len) ^ parity_odd ^ rx_par_q);
	assign rx_word = rx_sh_q;

	// Receive holding register and error flags; set beats clear
	always_ff @(posedge mclk) begin
		if (!rst_n || programmable_clear) begin
			rx_holding_reg_q <= '0;
			rx_full_q <= 1'b0;
			frame_err <= 1'b0;
			parity_err <= 1'b0;
			overrun_err <= 1'b0;
			rx_addr_flag <= 1'b0;
		end else begin
			if (rx_rd) begin
				rx_full_q <= 1'b0;
			end
			if (err_clear) begin
				frame_err <= 1'b0;
				parity_err <= 1'b0;
				overrun_err <= 1'b0;
			end
			if (rx_done) begin
				if (rx_fe) begin
					frame_err <= 1'b1;
				end
				if (rx_pe) begin
					parity_err <= 1'b1;
				end
				if (!rx_fifo_on) begin
					if (rx_full_q && !rx_rd) begin
						overrun_err <= 1'b1;
					end else begin
						rx_holding_reg_q <= rx_word;
						rx_full_q <= 1'b1;
						rx_addr_flag <= mp && rx_par_q;
					end
				end else if (rxf_full) begin
					overrun_err <= 1'b1;
				end
			end
		end
	end
	assign rx_data = rx_fifo_on ? rxf_q : rx_holding_reg_q;
	assign rx_full = rx_fifo_on ? !rxf_empty : rx_full_q;

	// Requests; slave_role has no effect, data frames are received in either role
	assign tx_empty = tx_fifo_on ? !txf_full : !tx_hold_full_q;
	assign tx_idle = (tx_st_q == ASU_IDLE) && !tx_src_ok;
	assign rx_irq = (rx_fifo_on ? (rxf_lvl >= rx_fifo_level &&
	                 !rxf_empty) : rx_full_q) ||
	                frame_err || parity_err || overrun_err;
	assign tx_irq = active && tx_empty;
	assign tx_idle_irq = active && tx_idle;
	assign tx_fifo_irq = active && tx_fifo_on && txf_empty;
	assign rx_dma_req = rx_irq && !frame_err && !parity_err &&
	                    !overrun_err;
	assign tx_dma_req = tx_irq;
	assign rts_n = flow_en && (rx_fifo_on ? rxf_full : rx_full_q);
	// Inputs used only by software convention
	logic unused_slave;
	assign unused_slave = slave_role;
endmodule // asu_uart

/* File: core/asu_pkg.sv */
// Constants and types shared by the asynchronous serial block
package asu_pkg;
	localparam logic [2:0] ASU_MODE_NORMAL = 3'h0;
	localparam logic [2:0] ASU_MODE_MULTIPROC = 3'h1;
	localparam int ASU_RELOAD_W = 15;
	localparam int ASU_FIFO_DEPTH = 16;
	localparam int ASU_FIFO_AW = 4;
	localparam int ASU_CHAR_W = 9;
	localparam logic [ASU_RELOAD_W-1:0] ASU_RELOAD_RST = 15'h0000;
	localparam logic [1:0] ASU_OVERSAMPLE = 2'h3;
	localparam logic [3:0] ASU_LEN_MIN = 4'h5;
	localparam logic [3:0] ASU_LEN_MAX = 4'h9;
	localparam logic [3:0] ASU_LEN_MP7 = 4'h7;
	localparam logic [3:0] ASU_LEN_MP8 = 4'h8;
	typedef enum logic [3:0] {
		ASU_IDLE = 4'b0001,
		ASU_START = 4'b0010,
		ASU_DATA = 4'b0100,
		ASU_STOP = 4'b1000
	} asu_state_type;
endpackage

/* File: core/asu_fifo.sv */
// Synchronous FIFO with reset, level output and resend rewind
`timescale 1ns/1ps
module asu_fifo
	import asu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic rewind,
	input wire logic wr_en,
	input wire logic [ASU_CHAR_W-1:0] wr_data,
	input wire logic rd_en,
	output logic [ASU_CHAR_W-1:0] rd_data,
	output logic empty,
	output logic full,
	output logic [ASU_FIFO_AW:0] level
);
	logic [ASU_CHAR_W-1:0] mem [ASU_FIFO_DEPTH];
	logic [ASU_FIFO_AW:0] wp_q;
	logic [ASU_FIFO_AW:0] rp_q;
	logic [ASU_FIFO_AW:0] mark_q;
	logic do_wr;
	logic do_rd;

	// Handshake terms
	assign empty = (wp_q == rp_q);
	assign full = (level == ASU_FIFO_AW'(0) + (ASU_FIFO_AW+1)'(ASU_FIFO_DEPTH));
	assign level = wp_q - rp_q;
	assign do_wr = wr_en && !full;
	assign do_rd = rd_en && !empty;
	assign rd_data = mem[rp_q[ASU_FIFO_AW-1:0]];

	// Storage
	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem[wp_q[ASU_FIFO_AW-1:0]] <= wr_data;
		end
	end

	// Pointers; mark holds the start of data kept for resend
	always_ff @(posedge mclk) begin
		if (!rst_n || clear) begin
			wp_q <= '0;
			rp_q <= '0;
			mark_q <= '0;
		end else if (rewind) begin
			rp_q <= mark_q;
		end else begin
			if (do_wr) begin
				wp_q <= wp_q + 1'b1;
			end
			if (do_rd) begin
				rp_q <= rp_q + 1'b1;
			end
			if (do_wr && full == 1'b0 && wp_q - mark_q ==
			    (ASU_FIFO_AW+1)'(ASU_FIFO_DEPTH)) begin
				mark_q <= mark_q + 1'b1;
			end
		end
	end
endmodule // asu_fifo

/* File: verification/asu_uart_assertions.sv */
// Port-level timing checks for the serial transceiver
`timescale 1ns/1ps
module asu_uart_chk
	import asu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic mode_select_bit2,
	input wire logic mode_select_bit1,
	input wire logic mode_select_bit0,
	input wire logic programmable_clear,
	input wire logic invert_nrz,
	input wire logic [ASU_RELOAD_W-1:0] baud_reload,
	input wire logic ext_clk_sel,
	input wire logic flow_en,
	input wire logic cts_n,
	input wire logic rts_n,
	input wire logic fifo1_en,
	input wire logic fifo2_en,
	input wire logic err_clear,
	input wire logic rx_full,
	input wire logic parity_err,
	input wire logic frame_err,
	input wire logic overrun_err,
	input wire logic tx_empty,
	input wire logic tx_idle,
	input wire logic txd,
	input wire logic rx_irq
);
	logic [2:0] mode;
	logic idle_lvl;
	logic no_fifo;
	// Decoded mode, line idle level, holding-register mode
	assign mode = {mode_select_bit2, mode_select_bit1, mode_select_bit0};
	assign idle_lvl = !invert_nrz;
	assign no_fifo = !fifo1_en && !fifo2_en;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_mode_gate: assert property (
		mode > 3'h1 && $past(mode) > 3'h1 && $stable(invert_nrz)
		|-> txd == idle_lvl) else $error("txd active outside async modes");
	a_bit_hold: assert property (
		$changed(txd) && !ext_clk_sel && baud_reload != 15'h0000
		|=> $stable(txd)[*4]) else $error("txd bit shorter than bit time");
	a_idle_line: assert property (
		tx_idle && $stable(invert_nrz) |-> txd == idle_lvl)
		else $error("line not idle while idle flag set");
	a_cts_pause: assert property (
		flow_en && cts_n && no_fifo && !tx_empty && !programmable_clear
		|=> !tx_empty) else $error("frame started without clear");
	a_rts_throttle: assert property (
		flow_en && no_fifo && rx_full |-> rts_n)
		else $error("peer not throttled while holding full");
	a_frame_sticky: assert property (
		frame_err && !err_clear && !programmable_clear |=> frame_err)
		else $error("framing flag lost without clear");
	a_ovr_sticky: assert property (
		overrun_err && !err_clear && !programmable_clear |=> overrun_err)
		else $error("overrun flag lost without clear");
	a_mp_parity: assert property (
		mode == 3'h1 && $past(mode) == 3'h1 && !$past(parity_err)
		|-> !parity_err) else $error("parity flag in multiprocessor mode");
	a_rx_cause: assert property (
		no_fifo |-> rx_irq == (rx_full || parity_err || frame_err
		|| overrun_err)) else $error("receive request without cause");
endmodule // asu_uart_chk

bind asu_uart asu_uart_chk u_chk (.mclk, .rst_n, .mode_select_bit2,
	.mode_select_bit1, .mode_select_bit0, .programmable_clear,
	.invert_nrz, .baud_reload, .ext_clk_sel, .flow_en, .cts_n, .rts_n,
	.fifo1_en, .fifo2_en, .err_clear, .rx_full, .parity_err, .frame_err,
	.overrun_err, .tx_idle, .txd, .rx_irq, .tx_empty);

/* File: verification/asu_peer.sv */
// Serial line peer: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps
module asu_peer #(parameter int BIT = 12) (
	input wire logic mclk,
	input wire logic txd,
	input wire logic inv,
	input wire logic honor,
	input wire logic rts_n,
	input wire logic [3:0] nbits,
	output logic rxd
);
	logic [8:0] cap_q[$];
	logic [8:0] w;
	logic lvl = 1'b1;
	// Logical level to line polarity
	assign rxd = lvl ^ inv;
	// One frame, LSB first, stop bit optionally broken
	task automatic send(input logic [8:0] d, input logic bad);
		int i;
		for (i = 0; i < 900 && honor && rts_n; i++) @(negedge mclk);
		lvl = 1'b0;
		repeat (BIT) @(negedge mclk);
		for (i = 0; i < nbits; i++) begin
			lvl = d[i];
			repeat (BIT) @(negedge mclk);
		end
		lvl = !bad;
		repeat (BIT) @(negedge mclk);
		lvl = 1'b1;
		repeat (2 * BIT) @(negedge mclk);
	endtask
	// Capture: start edge, confirm at mid-bit, sample centres
	always begin
		do @(negedge mclk); while (txd !== inv);
		repeat (BIT / 2) @(negedge mclk);
		if (txd === inv) begin
			w = 9'h000;
			for (int k = 0; k < nbits; k++) begin
				repeat (BIT) @(negedge mclk);
				w[k] = txd ^ inv;
			end
			repeat (BIT) @(negedge mclk);
			cap_q.push_back(w);
		end
	end
endmodule // asu_peer

/* File: verification/test_async_serial_uart_fifo.sv */
// Self-checking bench of the asynchronous serial transceiver
`timescale 1ns/1ps
`define CHK(a, b) chk_val(32'(a), 32'(b))
module test_async_serial_uart_fifo;
	import asu_pkg::*;
	localparam int BIT = 12;
	logic mclk = 1'b0;
	logic rst_n, mode_select_bit2, mode_select_bit1, mode_select_bit0;
	logic programmable_clear, invert_nrz, slave_role, flow_en, cts_n;
	logic fifo1_en, fifo1_is_rx, fifo2_en, fifo2_is_rx, fifo1_reset;
	logic fifo2_reset, tx_wr, rx_rd, err_clear, rts_n, rx_full, txd, rxd;
	logic rx_addr_flag, parity_err, frame_err, overrun_err, tx_empty;
	logic tx_idle, rx_irq, tx_irq, tx_idle_irq, tx_fifo_irq, parity_en;
	logic [3:0] char_len, nb;
	logic [4:0] rx_fifo_level;
	logic [8:0] tx_data, rx_data, rm, d, e;
	logic [8:0] q[3];
	integer seed, n_fail, cmp_count;
	asu_uart DUT (.mclk, .rst_n, .mode_select_bit2, .mode_select_bit1,
		.mode_select_bit0, .programmable_clear, .char_len, .parity_en,
		.parity_odd(1'b0), .invert_nrz, .baud_reload(15'h0003),
		.ext_clk_sel(1'b0), .ext_clk(1'b0), .slave_role, .flow_en, .cts_n,
		.rts_n, .fifo1_en, .fifo1_is_rx, .fifo2_en, .fifo2_is_rx,
		.fifo1_reset, .fifo2_reset, .tx_resend(1'b0), .rx_fifo_level, .tx_wr,
		.tx_data, .rx_rd, .err_clear, .rx_data, .rx_full, .rx_addr_flag,
		.parity_err, .frame_err, .overrun_err, .tx_empty, .tx_idle, .txd,
		.rxd, .rx_irq, .tx_irq, .tx_idle_irq, .tx_fifo_irq, .rx_dma_req(),
		.tx_dma_req());
	asu_peer #(.BIT(BIT)) peer (.mclk, .txd, .inv(invert_nrz),
		.honor(flow_en), .rts_n, .nbits(nb), .rxd);
	always #25 mclk = ~mclk;
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] a, input logic [31:0] b);
		cmp_count++;
		if (a !== b) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, a, b);
		end
	endtask
	function automatic logic [8:0] msk(input logic [8:0] v, input int n);
		return v & 9'((1 << n) - 1);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic pulse_clr();
		err_clear = 1'b1;
		rx_rd = 1'b1;
		cyc(1);
		err_clear = 1'b0;
		rx_rd = 1'b0;
		cyc(1);
	endtask
	task automatic wr(input logic [8:0] v);
		tx_data = v;
		tx_wr = 1'b1;
		cyc(1);
		tx_wr = 1'b0;
		cyc(1);
	endtask
	task automatic wait_cap(input int n);
		for (int i = 0; i < 4000 && peer.cap_q.size() < n; i++) cyc(1);
	endtask
	task automatic rd(input logic [8:0] x);
		for (int i = 0; i < 4000 && rx_full !== 1'b1; i++) cyc(1);
		`CHK(rx_data & rm, x);
		rx_rd = 1'b1;
		cyc(1);
		rx_rd = 1'b0;
		cyc(1);
	endtask
	// Full duplex frame: t out on txd, r in on rxd, x expected
	task automatic duplex(input logic [8:0] t, r, x);
		peer.cap_q.delete();
		fork
			wr(t);
			peer.send(r, 1'b0);
		join
		wait_cap(1);
		`CHK(peer.cap_q[0], t);
		rd(x);
	endtask
	task automatic set_mode(input logic [2:0] m);
		programmable_clear = 1'b1;
		cyc(1);
		{mode_select_bit2, mode_select_bit1, mode_select_bit0} = m;
		programmable_clear = 1'b0;
		cyc(2);
	endtask
	initial begin
		#(50 * 60000);
		n_fail++;
		give_verdict();
	end
	// Main sequence
	initial begin
		{rst_n, mode_select_bit2, mode_select_bit1, mode_select_bit0} = 0;
		{programmable_clear, invert_nrz, slave_role, flow_en} = 0;
		{fifo1_en, fifo1_is_rx, fifo2_en, fifo2_is_rx, fifo1_reset} = 0;
		{fifo2_reset, tx_wr, rx_rd, err_clear, parity_en} = 0;
		cts_n = 1'b0;
		char_len = 4'h8;
		nb = 4'h8;
		rm = 9'h1ff;
		rx_fifo_level = 5'h02;
		tx_data = 9'h000;
		seed = 95;
		n_fail = 0;
		cmp_count = 0;
		cyc(12);
		rst_n = 1'b1;
		cyc(2);
		`CHK(txd, 1'b1);
		`CHK(tx_idle_irq, 1'b1);
		for (int n = 5; n <= 9; n++) begin
			char_len = 4'(n);
			nb = 4'(n);
			d = msk(9'($random(seed)), n);
			e = msk(9'($random(seed)), n);
			duplex(d, e, e);
		end
		duplex(9'h1ff, 9'h000, 9'h000);
		char_len = 4'h8;
		nb = 4'h8;
		invert_nrz = 1'b1;
		cyc(BIT);
		d = msk(9'($random(seed)), 8);
		duplex(d, ~d & 9'h0ff, ~d & 9'h0ff);
		`CHK(txd, 1'b0);
		invert_nrz = 1'b0;
		cyc(BIT);
		peer.send(9'h0a5, 1'b1);
		`CHK(frame_err, 1'b1);
		`CHK(rx_irq, 1'b1);
		pulse_clr();
		`CHK(frame_err, 1'b0);
		peer.send(9'h011, 1'b0);
		peer.send(9'h022, 1'b0);
		`CHK(overrun_err, 1'b1);
		pulse_clr();
		parity_en = 1'b1;
		nb = 4'h9;
		d = msk(9'($random(seed)), 8);
		e = msk(9'($random(seed)), 8);
		duplex({^d, d[7:0]}, {^e, e[7:0]}, e);
		`CHK(parity_err, 1'b0);
		peer.send({~^e, e[7:0]}, 1'b0);
		`CHK(parity_err, 1'b1);
		pulse_clr();
		parity_en = 1'b0;
		nb = 4'h8;
		flow_en = 1'b1;
		cts_n = 1'b1;
		peer.cap_q.delete();
		wr(9'h03c);
		peer.send(9'h05a, 1'b0);
		`CHK(rts_n, 1'b1);
		`CHK(peer.cap_q.size(), 0);
		`CHK(tx_irq, 1'b0);
		rd(9'h05a);
		cts_n = 1'b0;
		for (int i = 0; i < 200 && tx_empty !== 1'b1; i++) cyc(1);
		`CHK(tx_irq, 1'b1);
		`CHK(tx_empty, 1'b1);
		`CHK(txd, 1'b0);
		`CHK(tx_idle, 1'b0);
		wait_cap(1);
		`CHK(peer.cap_q[0], 9'h03c);
		flow_en = 1'b0;
		slave_role = 1'b1;
		set_mode(ASU_MODE_MULTIPROC);
		parity_en = 1'b1;
		for (int n = 7; n <= 8; n++) begin
			char_len = 4'(n);
			nb = 4'(n + 1);
			rm = msk(9'h1ff, n);
			d = msk(9'($random(seed)), n);
			e = msk(9'($random(seed)), n);
			duplex(d, e | 9'(1 << n), e);
			`CHK(rx_addr_flag, 1'b1);
			`CHK(parity_err, 1'b0);
		end
		nb = 4'h8;
		char_len = 4'h8;
		rm = 9'h0ff;
		parity_en = 1'b0;
		set_mode(3'h2);
		peer.cap_q.delete();
		wr(9'h077);
		cyc(15 * BIT);
		`CHK(peer.cap_q.size(), 0);
		set_mode(ASU_MODE_NORMAL);
		fifo1_reset = 1'b1;
		fifo2_reset = 1'b1;
		cyc(1);
		{fifo1_reset, fifo2_reset} = 2'b00;
		{fifo1_en, fifo2_en, fifo2_is_rx} = 3'b111;
		cyc(1);
		peer.cap_q.delete();
		tx_wr = 1'b1;
		for (int k = 0; k < 3; k++) begin
			q[k] = msk(9'($random(seed)), 8);
			tx_data = q[k];
			cyc(1);
		end
		tx_wr = 1'b0;
		wait_cap(3);
		for (int k = 0; k < 3; k++) `CHK(peer.cap_q[k], q[k]);
		`CHK(tx_fifo_irq, 1'b1);
		peer.send(q[0], 1'b0);
		`CHK(rx_irq, 1'b0);
		peer.send(q[1], 1'b0);
		`CHK(rx_irq, 1'b1);
		fifo1_reset = 1'b1;
		cyc(1);
		fifo1_reset = 1'b0;
		rd(q[0]);
		rd(q[1]);
		give_verdict();
	end
endmodule // test_async_serial_uart_fifo
